// ==== logic/host_if_strap_select.sv ====
/*
  Mode strap and host interface selection, wake input, activation LED,
  free-running auxiliary clock, open-drain reset output and interrupt pin.
  Assumes pins are asynchronous (synchronised inside); software-side
  controls arrive on the same clock as plain ports.
*/
`timescale 1ns/1ns
module host_if_strap_select
  import strap_pkg::*;
#(
  parameter int unsigned WAKE_RESET_LEN = WAKE_RESET_CYCLES
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // strap and mode pins
  input  wire logic                 primary_mode_select,
  input  wire logic                 line_mode_select,
  input  wire logic                 write_strobe,
  input  wire logic                 read_strobe,
  input  wire logic                 chip_select_n,
  input  wire logic                 addr_latch,
  input  wire logic                 reset_input_pin_n,
  // software controls
  input  wire logic                 wake_reset_enable,
  input  wire logic                 led_auto,
  input  wire logic                 led_value,
  input  wire logic                 irq_active_high,
  input  wire logic                 irq_source_pending,
  input  wire logic                 wake_irq_clear,
  input  wire logic                 host_reset_request,
  // device state
  input  wire logic                 s_activated,
  input  wire logic                 watchdog_timeout,
  // selection results
  output      strap_pkg::op_mode_t  op_mode,
  output      strap_pkg::host_if_t  host_if,
  output logic                      monitor_slave,
  output logic                      wake_irq_pending,
  // pins out
  output logic                      activation_led_output,
  output logic                      aux_clock_output,
  output logic                      reset_output_pin_out,
  output logic                      reset_output_pin_oe,
  output logic                      irq_out
);
  import strap_pkg::*;

  // ************************************
  // pin synchroniser
  // ************************************
  pin_sync_if #(.WIDTH(PIN_COUNT)) pins ();

  assign pins.raw[PIN_PRIMARY] = primary_mode_select;
  assign pins.raw[PIN_LINE]    = line_mode_select;
  assign pins.raw[PIN_WRITE]   = write_strobe;
  assign pins.raw[PIN_READ]    = read_strobe;
  assign pins.raw[PIN_SELECT]  = chip_select_n;
  assign pins.raw[PIN_LATCH]   = addr_latch;
  assign pins.raw[PIN_RESET]   = reset_input_pin_n;

  pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pins  (pins)
  );

  logic in_reset;
  logic latch_edge;
  logic strobes_high;
  logic strobes_low;

  assign in_reset     = ~pins.level[PIN_RESET];
  assign latch_edge   = pins.rise[PIN_LATCH] | pins.fall[PIN_LATCH];
  assign strobes_high = pins.level[PIN_WRITE] & pins.level[PIN_READ];
  assign strobes_low  = ~pins.level[PIN_WRITE] & ~pins.level[PIN_READ];

  // ************************************
  // operating mode strap
  // ************************************
  op_mode_t next_op_mode;

  always_comb begin
    if (!pins.level[PIN_PRIMARY]) begin
      next_op_mode = terminal_mode;
    end else if (!pins.level[PIN_LINE]) begin
      next_op_mode = trunk_line_mode;
    end else begin
      next_op_mode = subscriber_line_mode;
    end
  end

  // only follows the pins while the reset input is held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_mode <= OP_MODE_RESET;
    end else if (in_reset) begin
      op_mode <= next_op_mode;
    end
  end

  // ************************************
  // host interface strap
  // ************************************
  host_if_t next_host_if;

  always_comb begin
    next_host_if = no_host;
    if (strobes_high && pins.level[PIN_SELECT]) begin
      next_host_if = pins.level[PIN_LATCH] ? bus_strobe_dir : bus_separate_addr;
    end else if (strobes_low && pins.level[PIN_SELECT] && !pins.level[PIN_LATCH]) begin
      next_host_if = serial_ctrl_port;
    end else if (strobes_low && !pins.level[PIN_SELECT]) begin
      next_host_if = no_host;
    end
  end

  logic mux_take;
  logic strap_take;

  assign mux_take   = latch_edge & (in_reset ? strobes_high : 1'b1);
  assign strap_take = in_reset & ~(host_if == bus_multiplexed && strobes_high);

  // a latch edge is sticky: once multiplexed, only the reset input undoes it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_if <= HOST_IF_RESET;
    end else if (mux_take) begin
      host_if <= bus_multiplexed;
    end else if (strap_take) begin
      host_if <= next_host_if;
    end
  end

  // kept in step with host_if so the flag never disagrees with the kind
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      monitor_slave <= 1'b1;
    end else if (mux_take) begin
      monitor_slave <= 1'b0;
    end else if (strap_take) begin
      // slave over the monitor channel; too slow for HDLC data
      monitor_slave <= (next_host_if == no_host);
    end
  end

  // ************************************
  // external wake
  // ************************************
  logic wake_event;

  assign wake_event = (op_mode == terminal_mode) & ~in_reset & pins.fall[PIN_LINE];

  // set wins over clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_irq_pending <= 1'b0;
    end else if (wake_event) begin
      wake_irq_pending <= 1'b1;
    end else if (wake_irq_clear) begin
      wake_irq_pending <= 1'b0;
    end
  end

  logic [15:0] wake_reset_count;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_reset_count <= 16'h0000;
    end else if (wake_event && wake_reset_enable) begin
      wake_reset_count <= 16'(WAKE_RESET_LEN);
    end else if (wake_reset_count != 16'h0000) begin
      wake_reset_count <= wake_reset_count - 16'h0001;
    end
  end

  // ************************************
  // reset output, open drain
  // ************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reset_output_pin_out <= 1'b0;
      reset_output_pin_oe  <= 1'b0;
    end else begin
      reset_output_pin_out <= 1'b0;
      // enable pulls low; released line floats high
      reset_output_pin_oe  <= watchdog_timeout | host_reset_request |
                              (wake_reset_count != 16'h0000);
    end
  end

  // ************************************
  // interrupt pin
  // ************************************
  logic irq_any;

  assign irq_any = irq_source_pending | wake_irq_pending;

  // level output, no alignment to host cycles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_out <= 1'b1;
    end else begin
      irq_out <= irq_active_high ? irq_any : ~irq_any;
    end
  end

  // ************************************
  // activation LED
  // ************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      activation_led_output <= 1'b1;
    end else begin
      activation_led_output <= led_auto ? ~s_activated : led_value;
    end
  end

  // ************************************
  // auxiliary clock
  // ************************************
  logic [PHASE_BITS-1:0] phase;

  // phase accumulator: average rate just under AUX_CLOCK_HZ (step rounded down), edges jitter by one clock period
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase <= '0;
    end else begin
      phase <= phase + PHASE_STEP;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aux_clock_output <= 1'b0;
    end else begin
      aux_clock_output <= phase[PHASE_BITS-1];
    end
  end

endmodule // host_if_strap_select

// ==== logic/pin_sync.sv ====
/*
  Two-flop synchroniser plus edge detector for a vector of pins.
  Assumes the pins are asynchronous to clock; edges are one-cycle pulses.
*/
`timescale 1ns/1ns
module pin_sync
  import strap_pkg::*;
#(
  parameter int unsigned WIDTH = PIN_COUNT
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // pins
  pin_sync_if.sync  pins
);

  // ************************************
  // edge enable
  // ************************************
  // edges stay quiet until the prior flop holds a real pin level;
  // otherwise a pin strapped high looks like a rise just after reset
  logic [1:0] fill;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fill <= 2'h0;
    end else if (fill != 2'h3) begin
      fill <= fill + 2'h1;
    end
  end

  // ************************************
  // per-pin stages
  // ************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic meta;
      logic stable;
      logic prior;
      // meta is read by stable only
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          meta   <= PIN_RESET_VALUE[i];
          stable <= PIN_RESET_VALUE[i];
          prior  <= PIN_RESET_VALUE[i];
        end else begin
          meta   <= pins.raw[i];
          stable <= meta;
          prior  <= stable;
        end
      end
      assign pins.level[i] = stable;
      assign pins.rise[i]  = (fill == 2'h3) & stable & ~prior;
      assign pins.fall[i]  = (fill == 2'h3) & ~stable & prior;
    end
  endgenerate

endmodule // pin_sync

// ==== logic/pin_sync_if.sv ====
/*
  Carrier between the strap logic and its pin synchroniser: raw pins in,
  synchronised levels and one-cycle edge pulses out.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface pin_sync_if #(parameter int unsigned WIDTH = 7);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  modport user (output raw, input level, input rise, input fall);
  modport sync (input raw, output level, output rise, output fall);
endinterface // pin_sync_if

// ==== logic/strap_pkg.sv ====
/*
  Shared types and constants for the strap selection block: operating modes,
  host interface kinds, pin positions in the sampled pin vector, timing.
  Assumes a single 50 MHz clock and a synchronous active-low reset.
*/
package strap_pkg;

  // ************************************
  // clock and timing
  // ************************************
  localparam int unsigned CLOCK_HZ         = 50_000_000;
  localparam int unsigned AUX_CLOCK_HZ     = 7_680_000;
  localparam int unsigned PHASE_BITS       = 16;
  // phase step per cycle, rounded down to whole units of 2**-16
  localparam longint unsigned PHASE_STEP_L =
    (longint'(AUX_CLOCK_HZ) * (longint'(1) << PHASE_BITS)) / longint'(CLOCK_HZ);
  localparam logic [PHASE_BITS-1:0] PHASE_STEP = PHASE_STEP_L[PHASE_BITS-1:0];
  localparam int unsigned WAKE_RESET_NS    = 320;
  localparam int unsigned WAKE_RESET_CYCLES =
    (WAKE_RESET_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

  // ************************************
  // sampled pin positions
  // ************************************
  localparam int unsigned PIN_COUNT    = 7;
  localparam int unsigned PIN_PRIMARY  = 0;
  localparam int unsigned PIN_LINE     = 1;
  localparam int unsigned PIN_WRITE    = 2;
  localparam int unsigned PIN_READ     = 3;
  localparam int unsigned PIN_SELECT   = 4;
  localparam int unsigned PIN_LATCH    = 5;
  localparam int unsigned PIN_RESET    = 6;
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VALUE = 7'h00;

  // ************************************
  // modes
  // ************************************
  typedef enum logic [1:0] {
    terminal_mode,
    trunk_line_mode,
    subscriber_line_mode
  } op_mode_t;

  typedef enum logic [2:0] {
    bus_strobe_dir,
    bus_separate_addr,
    bus_multiplexed,
    serial_ctrl_port,
    no_host
  } host_if_t;

  localparam op_mode_t OP_MODE_RESET = terminal_mode;
  localparam host_if_t HOST_IF_RESET = no_host;

endpackage

// ==== verification/strap_host_model.sv ====
/*
  Far-side strap model: drives the host interface strap pins for a wanted
  host kind, with a toggle that flips the latch pin.
  Assumes the bench holds want and toggle steady between changes.
*/
`timescale 1ns/1ns
module strap_host_model
  import strap_pkg::*;
(
  // requests
  input  wire strap_pkg::host_if_t want,
  input  wire logic                toggle,
  // strap pins
  output logic                     write_strobe,
  output logic                     read_strobe,
  output logic                     chip_select_n,
  output logic                     addr_latch
);
  import strap_pkg::*;
  logic [3:0] pins;
  // ****
  // strap table
  // ****
  always_comb begin
    case (want)
      bus_strobe_dir:    pins = 4'hF;
      bus_separate_addr: pins = 4'hE;
      serial_ctrl_port:  pins = 4'h2;
      default:           pins = 4'h0;
    endcase
  end
  assign {write_strobe, read_strobe, chip_select_n} = pins[3:1];
  assign addr_latch = pins[0] ^ toggle;
endmodule // strap_host_model

// ==== verification/strap_select_properties.sv ====
/*
  Checker of port timing for the strap selection block.
  Assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/1ns
module strap_select_checker
  import strap_pkg::*;
#(parameter int unsigned WAKE_RESET_LEN = 16)
(
  input wire logic clock, rst_n, line_mode_select, addr_latch, reset_input_pin_n,
  input wire logic wake_reset_enable, led_auto, led_value, irq_active_high,
  input wire logic irq_source_pending, host_reset_request, s_activated,
  input wire logic watchdog_timeout, monitor_slave, wake_irq_pending,
  input wire logic activation_led_output, reset_output_pin_out, reset_output_pin_oe,
  input wire logic irq_out,
  input wire strap_pkg::op_mode_t op_mode,
  input wire strap_pkg::host_if_t host_if
);
  import strap_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // run length of the reset drive, cleared by the level causes
  logic [7:0] oe_run;
  always_ff @(posedge clock) begin
    if (!rst_n || !reset_output_pin_oe || watchdog_timeout || host_reset_request)
      oe_run <= 8'h00;
    else if (oe_run != 8'hFF)
      oe_run <= oe_run + 8'h01;
  end
  sequence settled;
    reset_input_pin_n [*6];
  endsequence
  sequence wake_fall;
    settled ##0 (op_mode == terminal_mode && $fell(line_mode_select));
  endsequence
  chk_irq_low_pol: assert property (!irq_active_high && irq_source_pending |=> !irq_out)
    else $error("irq not low");
  chk_irq_high_pol: assert property (irq_active_high && irq_source_pending |=> irq_out)
    else $error("irq not high");
  chk_led_manual: assert property (!led_auto |=> activation_led_output == $past(led_value))
    else $error("led not manual");
  chk_led_auto: assert property (led_auto && s_activated |=> !activation_led_output)
    else $error("led not low");
  chk_reset_cause: assert property (watchdog_timeout || host_reset_request |=> reset_output_pin_oe)
    else $error("reset not driven");
  chk_reset_level: assert property (reset_output_pin_oe |-> !reset_output_pin_out)
    else $error("reset drives high");
  chk_mode_hold: assert property (settled |=> $stable(op_mode))
    else $error("mode moved");
  chk_host_hold: assert property (settled |=> $stable(host_if) || host_if == bus_multiplexed)
    else $error("host kind moved");
  chk_mux_edge: assert property (settled ##0 $changed(addr_latch) |-> ##[1:4] host_if == bus_multiplexed)
    else $error("no mux");
  chk_wake_flag: assert property (wake_fall |-> ##[1:4] wake_irq_pending)
    else $error("no wake flag");
  chk_wake_reset: assert property (wake_fall ##0 wake_reset_enable |-> ##[1:6] reset_output_pin_oe)
    else $error("no wake reset");
  chk_wake_len: assert property (oe_run <= WAKE_RESET_LEN)
    else $error("wake reset too long");
  chk_no_host_flag: assert property (monitor_slave == (host_if == no_host))
    else $error("monitor flag wrong");
endmodule // strap_select_checker
bind host_if_strap_select strap_select_checker #(.WAKE_RESET_LEN(WAKE_RESET_LEN))
  strap_select_checker_inst (.*);

// ==== verification/tb_host_if_strap_select.sv ====
/*
  Self-checking bench for the strap selection block and its strap model.
  Assumes strap_pkg, the design files and the checker are compiled first.
*/
`timescale 1ns/1ns
module tb_host_if_strap_select;
  import strap_pkg::*;
  localparam int unsigned WL = 4;
  logic clock = 0, rst_n = 0, reset_input_pin_n = 0, toggle = 0, wake_irq_clear = 0;
  logic primary_mode_select = 0, line_mode_select = 0, wake_reset_enable = 1;
  logic led_auto = 0, led_value = 0, irq_active_high = 0, irq_source_pending = 0;
  logic host_reset_request = 0, s_activated = 0, watchdog_timeout = 0;
  logic write_strobe, read_strobe, chip_select_n, addr_latch, monitor_slave;
  logic wake_irq_pending, activation_led_output, aux_clock_output, irq_out;
  logic reset_output_pin_out, reset_output_pin_oe, reset_line;
  host_if_t want = bus_strobe_dir, host_if;
  op_mode_t op_mode;
  int failures = 0, check_count = 0;
  // open-drain reset line with pull-up
  assign reset_line = reset_output_pin_oe ? reset_output_pin_out : 1'b1;
  host_if_strap_select #(.WAKE_RESET_LEN(WL)) host_if_strap_select_inst (.*);
  strap_host_model strap_host_model_inst (.*);
  initial forever #10 clock = ~clock;
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [7:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // pins change only after the reset pin is seen low, so no stray edges
  task automatic strap(input logic pm, lm, input host_if_t k, input op_mode_t m);
    reset_input_pin_n = 0;
    tick(3);
    primary_mode_select = pm;
    line_mode_select = lm;
    want = k;
    toggle = 0;
    tick(6);
    reset_input_pin_n = 1;
    tick(6);
    check(8'(op_mode), 8'(m), "op_mode");
    check(8'(host_if), 8'(k), "host_if");
    check(8'(monitor_slave), 8'(k == no_host), "monitor_slave");
    primary_mode_select = ~pm;
    tick(6);
    check(8'(op_mode), 8'(m), "op_mode held");
    primary_mode_select = pm;
    $display("strap test done");
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_wake();
    int k;
    int n;
    line_mode_select = 0;
    for (k = 0; k < 8 && wake_irq_pending !== 1'b1; k++) tick(1);
    check(8'(wake_irq_pending), 8'h01, "wake flag");
    n = 0;
    for (k = 0; k < 30; k++) begin
      if (reset_output_pin_oe === 1'b1) n++;
      tick(1);
    end
    check(8'(n), 8'(WL), "wake reset length");
    check(8'(irq_out), 8'h00, "wake irq");
    wake_irq_clear = 1;
    line_mode_select = 1;
    tick(1);
    wake_irq_clear = 0;
    tick(6);
    check(8'(wake_irq_pending), 8'h00, "wake on rise");
    check(8'(irq_out), 8'h01, "irq idle");
    wake_reset_enable = 0;
    line_mode_select = 0;
    n = 0;
    for (k = 0; k < 12; k++) begin
      if (reset_output_pin_oe === 1'b1) n++;
      tick(1);
    end
    check(8'(wake_irq_pending), 8'h01, "wake flag no reset");
    check(8'(n), 8'h00, "wake reset disabled");
    wake_irq_clear = 1;
    line_mode_select = 1;
    tick(1);
    wake_irq_clear = 0;
    wake_reset_enable = 1;
    tick(6);
    $display("wake test done");
  endtask
  task automatic test_mux();
    toggle = 1;
    tick(5);
    check(8'(host_if), 8'(bus_multiplexed), "latch edge");
    want = serial_ctrl_port;
    tick(5);
    check(8'(host_if), 8'(bus_multiplexed), "mux held");
    strap(1'b1, 1'b0, serial_ctrl_port, trunk_line_mode);
    $display("mux test done");
  endtask
  task automatic test_outputs();
    int k;
    int n;
    logic prev;
    line_mode_select = 1;
    tick(4);
    line_mode_select = 0;
    tick(6);
    check(8'(wake_irq_pending), 8'h00, "no wake in line mode");
    tick(2);
    check(8'(activation_led_output), 8'h00, "led manual");
    led_auto = 1;
    tick(2);
    check(8'(activation_led_output), 8'h01, "led idle");
    s_activated = 1;
    irq_source_pending = 1;
    tick(2);
    check(8'(activation_led_output), 8'h00, "led active");
    check(8'(irq_out), 8'h00, "irq low");
    irq_active_high = 1;
    watchdog_timeout = 1;
    tick(2);
    check(8'(irq_out), 8'h01, "irq high");
    check(8'(reset_line), 8'h00, "watchdog reset");
    watchdog_timeout = 0;
    host_reset_request = 1;
    tick(2);
    check(8'(reset_line), 8'h00, "host reset");
    host_reset_request = 0;
    tick(2);
    check(8'(reset_line), 8'h01, "reset off");
    n = 0;
    prev = aux_clock_output;
    for (k = 0; k < 1000; k++) begin
      tick(1);
      if (aux_clock_output === 1'b1 && prev === 1'b0) n++;
      prev = aux_clock_output;
    end
    // 7.68 MHz against 50 MHz gives about 153.6 rising edges per 1000 cycles
    check(8'(n >= 152 && n <= 155), 8'h01, "aux clock rate");
    $display("output test done");
  endtask
  initial begin
    tick(9);
    check(8'(irq_out), 8'h01, "reset irq");
    check(8'(reset_output_pin_oe), 8'h00, "reset oe");
    tick(1);
    rst_n = 1;
    strap(1'b0, 1'b0, bus_strobe_dir, terminal_mode);
    strap(1'b1, 1'b0, serial_ctrl_port, trunk_line_mode);
    strap(1'b1, 1'b1, no_host, subscriber_line_mode);
    strap(1'b0, 1'b1, bus_separate_addr, terminal_mode);
    test_wake();
    test_mux();
    test_outputs();
    close_out();
  end
  initial begin
    #(20 * 6000);
    failures++;
    $display("watchdog expired");
    close_out();
  end
endmodule // tb_host_if_strap_select
